// ===== tasm_cfg.svh
// register offsets, field positions, reset values and timing counts of the alarm block
`ifndef TASM_CFG_SVH
`define TASM_CFG_SVH

// register offsets on the byte-wide register port
`define TASM_ADDR_ALARM_STATUS 8'h02
`define TASM_ADDR_ALARM_MASK   8'h16
`define TASM_ADDR_POR_STATUS   8'h33

// alarm status and mask field positions
`define TASM_BIT_BUSY          7
`define TASM_BIT_LOCAL_HIGH    6
`define TASM_BIT_UNUSED        5
`define TASM_BIT_REMOTE_HIGH   4
`define TASM_BIT_REMOTE_LOW    3
`define TASM_BIT_DIODE_FAULT   2
`define TASM_BIT_CRITICAL      1
`define TASM_BIT_TACH          0

// bits that may raise the alert; also the writable mask bits
`define TASM_ALERT_BITS        8'h5B

// power-on-reset status field
`define TASM_BIT_NOT_READY     7

// reset values
`define TASM_STATUS_RST        8'h00
`define TASM_MASK_RST          8'h00
`define TASM_RDATA_RST         8'h00
`define TASM_UNMAPPED_RDATA    8'h00

// timing
`define TASM_CLK_PERIOD_NS     10
`define TASM_POR_TIME_NS       2000
`define TASM_POR_CYCLES        ((`TASM_POR_TIME_NS + `TASM_CLK_PERIOD_NS - 1) / `TASM_CLK_PERIOD_NS)
`define TASM_POR_CNT_W         8

`endif

// ===== tasm_pkg.sv
// types shared by the alarm status and mask block
package tasm_pkg;

	typedef logic [7:0] tasm_byte_t;

	typedef enum logic [0:0] {
		TASM_POR_RUN,
		TASM_POR_READY
	} tasm_por_state_t;

endpackage

// ===== tasm_por_seq.sv
// power-on-reset sequencer: holds the not-ready flag for the start-up cycle
`timescale 1ns/100ps
`include "tasm_cfg.svh"

module tasm_por_seq (
	input  wire logic clk_sys,
	input  wire logic resetn,
	output logic      not_ready
);

	tasm_pkg::tasm_por_state_t       state;
	logic [`TASM_POR_CNT_W-1:0]      cnt;

	////////////////////////////////////////////////////////////////////////////////
	// count the start-up cycle, then report ready for good
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= tasm_pkg::TASM_POR_RUN;
			cnt <= '0;
			not_ready <= 1'b1;
		end else begin
			case (state)
				tasm_pkg::TASM_POR_RUN: begin
					if (cnt == `TASM_POR_CNT_W'(`TASM_POR_CYCLES - 1)) begin
						state <= tasm_pkg::TASM_POR_READY;
						not_ready <= 1'b0; // RL16
					end else begin
						cnt <= cnt + `TASM_POR_CNT_W'(1);
						not_ready <= 1'b1;
					end
				end
				tasm_pkg::TASM_POR_READY: begin
					not_ready <= 1'b0;
				end
				default: begin
					state <= tasm_pkg::TASM_POR_RUN;
					not_ready <= 1'b1;
				end
			endcase
		end
	end

endmodule

// ===== tasm_top.sv
// alarm status, alarm mask and power-on-reset status registers with alert and critical outputs
`timescale 1ns/100ps
`include "tasm_cfg.svh"

// Function
// (RL1) alarms latch until read, clear if gone
// (RL2) status bit 7 shows conversion busy only
// (RL3) bit 6 flags local over-limit, raises alert
// (RL4) status bit 5 always reads zero
// (RL5) bit 4 flags remote over-limit, raises alert
// (RL6) bit 3 flags remote under-limit, raises alert
// (RL7) bit 2 diode fault, no alert, no critical
// (RL8) bit 1 critical: alert and critical output
// (RL9) bit 0 flags tach over-limit, raises alert
// (RL10) mask bit 6 blocks local high alert
// (RL11) mask bit 4 blocks remote high alert
// (RL12) mask bit 3 blocks remote low alert
// (RL13) mask bit 1 blocks critical alert
// (RL14) mask bit 0 blocks tach alert
// (RL15) mask bits 7, 5, 2 read one
// (RL16) reset status bit 7 set until ready
// (RL17) reset status bits 6:0 read zero
// (RL18) comparator mode follows live alert conditions
// (RL19) critical output holds until below limit minus hysteresis
// (RL20) alert on any unmasked latched alarm; in comparator mode the code alerts on live conditions only, not on latches
module tasm_top (
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	input  wire tasm_pkg::tasm_byte_t reg_addr,
	input  wire logic                reg_rd,
	input  wire logic                reg_wr,
	input  wire tasm_pkg::tasm_byte_t reg_wdata,
	output tasm_pkg::tasm_byte_t     reg_rdata,
	output logic                     reg_rvalid,
	input  wire logic                conv_busy,
	input  wire logic                local_over_limit_cond,
	input  wire logic                remote_over_limit_cond,
	input  wire logic                remote_under_limit_cond,
	input  wire logic                diode_fault_cond,
	input  wire logic                tach_over_limit_cond,
	input  wire tasm_pkg::tasm_byte_t remote_temp,
	input  wire tasm_pkg::tasm_byte_t critical_limit,
	input  wire logic [6:0]          crit_hysteresis,
	input  wire logic                comparator_mode_select,
	output logic                     alert_oe,
	output logic                     critical_temp_output,
	output logic                     reset_in_progress_flag
);

	tasm_pkg::tasm_byte_t cond_vec;
	tasm_pkg::tasm_byte_t latched;
	tasm_pkg::tasm_byte_t next_latched;
	tasm_pkg::tasm_byte_t alarm_mask;
	tasm_pkg::tasm_byte_t alert_src;
	tasm_pkg::tasm_byte_t status_view;
	tasm_pkg::tasm_byte_t mask_view;
	tasm_pkg::tasm_byte_t por_view;
	tasm_pkg::tasm_byte_t next_rdata;
	logic                 rd_status;
	logic                 wr_mask;
	logic                 crit_cond;
	logic                 crit_release;
	logic                 next_alert;
	logic                 next_crit;
	logic [8:0]           release_sum;

	////////////////////////////////////////////////////////////////////////////////
	// start-up sequencer; not-ready flag is a flop inside it
	tasm_por_seq i_tasm_por_seq (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.not_ready (reset_in_progress_flag)
	);

	////////////////////////////////////////////////////////////////////////////////
	// critical compare with hysteresis; sum form avoids underflow of limit - hyst
	assign crit_cond = remote_temp > critical_limit; // RL8
	assign release_sum = {1'b0, remote_temp} + {2'b00, crit_hysteresis};
	assign crit_release = release_sum < {1'b0, critical_limit}; // RL19

	// live alarm conditions in status bit order; busy and the unused bit never latch
	always_comb begin
		cond_vec = '0;
		cond_vec[`TASM_BIT_LOCAL_HIGH] = local_over_limit_cond; // RL3
		cond_vec[`TASM_BIT_REMOTE_HIGH] = remote_over_limit_cond; // RL5
		cond_vec[`TASM_BIT_REMOTE_LOW] = remote_under_limit_cond; // RL6
		cond_vec[`TASM_BIT_DIODE_FAULT] = diode_fault_cond; // RL7
		cond_vec[`TASM_BIT_CRITICAL] = crit_cond; // RL8
		cond_vec[`TASM_BIT_TACH] = tach_over_limit_cond; // RL9
	end

	////////////////////////////////////////////////////////////////////////////////
	// register port decode
	assign rd_status = reg_rd && (reg_addr == `TASM_ADDR_ALARM_STATUS);
	assign wr_mask = reg_wr && (reg_addr == `TASM_ADDR_ALARM_MASK);

	// a read clears only bits whose condition is gone; a new event in the
	// read cycle sets again, so the set always wins over the clear
	assign next_latched = cond_vec | (latched & ~{8{rd_status}}); // RL1

	// alarm latches
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			latched <= `TASM_STATUS_RST;
		end else begin
			latched <= next_latched; // RL1
		end
	end

	// mask register; only alert-capable bits hold state
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			alarm_mask <= `TASM_MASK_RST;
		end else if (wr_mask) begin
			alarm_mask <= reg_wdata & `TASM_ALERT_BITS; // RL10 RL11 RL12 RL13 RL14
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read views of the three registers
	always_comb begin
		status_view = latched;
		status_view[`TASM_BIT_BUSY] = conv_busy; // RL2
		status_view[`TASM_BIT_UNUSED] = 1'b0; // RL4
	end

	assign mask_view = alarm_mask | ~`TASM_ALERT_BITS; // RL15

	always_comb begin
		por_view = '0; // RL17
		por_view[`TASM_BIT_NOT_READY] = reset_in_progress_flag; // RL16
	end

	// read data mux; unmapped addresses return a fixed value
	always_comb begin
		case (reg_addr)
			`TASM_ADDR_ALARM_STATUS: begin
				next_rdata = status_view;
			end
			`TASM_ADDR_ALARM_MASK: begin
				next_rdata = mask_view;
			end
			`TASM_ADDR_POR_STATUS: begin
				next_rdata = por_view;
			end
			default: begin
				next_rdata = `TASM_UNMAPPED_RDATA;
			end
		endcase
	end

	// read data held until the next read, valid pulse one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= `TASM_RDATA_RST;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alert source: live conditions in comparator mode, latches otherwise;
	// busy and diode fault sit outside the alert bit set and never reach the pin
	assign alert_src = comparator_mode_select ? cond_vec : latched; // RL18 RL20
	assign next_alert = |(alert_src & `TASM_ALERT_BITS & ~alarm_mask); // RL2 RL7 RL10 RL11 RL12 RL13 RL14 RL20

	// alert pin pull-down enable
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			alert_oe <= 1'b0;
		end else begin
			alert_oe <= next_alert;
		end
	end

	// critical output sets above the limit, holds through the hysteresis band;
	// the mask has no say here, the output is for hard shutdown
	always_comb begin
		if (crit_cond) begin
			next_crit = 1'b1; // RL8
		end else if (crit_release) begin
			next_crit = 1'b0; // RL19
		end else begin
			next_crit = critical_temp_output; // RL19
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			critical_temp_output <= 1'b0;
		end else begin
			critical_temp_output <= next_crit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// a raised bit survives every cycle without a status read
	property p_status_hold;
		!rd_status |=> ((latched & $past(latched)) == $past(latched));
	endproperty
	a_status_hold: assert property (p_status_hold) // RL1
		else $error("alarm bit dropped without a status read");

	// a read with no condition left empties the latches
	property p_status_clear;
		(rd_status && (cond_vec == 8'h00)) |=> (latched == 8'h00);
	endproperty
	a_status_clear: assert property (p_status_clear) // RL1
		else $error("status read did not clear stale alarms");

	// busy bit returned matches the converter state at the strobe
	property p_busy_read;
		rd_status |=> (reg_rvalid && (reg_rdata[`TASM_BIT_BUSY] == $past(conv_busy)));
	endproperty
	a_busy_read: assert property (p_busy_read) // RL2
		else $error("busy bit read back wrong");

	// unused status bit is zero on every status read
	property p_unused_zero;
		rd_status |=> !reg_rdata[`TASM_BIT_UNUSED];
	endproperty
	a_unused_zero: assert property (p_unused_zero) // RL4
		else $error("unused status bit read as one");

	// each alarm condition lands in its status bit one cycle later
	property p_cond_latch;
		(cond_vec != 8'h00) |=> ((latched & $past(cond_vec)) == $past(cond_vec));
	endproperty
	a_cond_latch: assert property (p_cond_latch) // RL3 RL5 RL6 RL7 RL8 RL9
		else $error("alarm condition not latched");

	// nothing unmasked and alert-capable means no alert, diode fault included
	property p_alert_quiet;
		((latched | cond_vec) & `TASM_ALERT_BITS & ~alarm_mask) == 8'h00 |=> !alert_oe;
	endproperty
	a_alert_quiet: assert property (p_alert_quiet) // RL7 RL10 RL11 RL12 RL13 RL14
		else $error("alert raised with every source masked or idle");

	// latched mode: an unmasked latch drives the alert next cycle
	property p_alert_on;
		(!comparator_mode_select && ((latched & `TASM_ALERT_BITS & ~alarm_mask) != 8'h00))
			|=> alert_oe;
	endproperty
	a_alert_on: assert property (p_alert_on) // RL20
		else $error("unmasked alarm did not raise the alert");

	// comparator mode: alert drops once the unmasked conditions are gone
	property p_comp_mode;
		(comparator_mode_select && ((cond_vec & `TASM_ALERT_BITS & ~alarm_mask) == 8'h00))
			|=> !alert_oe;
	endproperty
	a_comp_mode: assert property (p_comp_mode) // RL18
		else $error("comparator mode alert stuck after condition cleared");

	// critical output rises with the critical alarm
	property p_crit_on;
		crit_cond |=> (critical_temp_output && latched[`TASM_BIT_CRITICAL]);
	endproperty
	a_crit_on: assert property (p_crit_on) // RL8
		else $error("critical output or flag missing above limit");

	// critical output holds inside the hysteresis band
	property p_crit_hold;
		(critical_temp_output && !crit_release) |=> critical_temp_output;
	endproperty
	a_crit_hold: assert property (p_crit_hold) // RL19
		else $error("critical output released inside hysteresis band");

	// mask register reserved bits always read one
	property p_mask_ones;
		(reg_rd && (reg_addr == `TASM_ADDR_ALARM_MASK))
			|=> ((reg_rdata & ~`TASM_ALERT_BITS) == ~`TASM_ALERT_BITS);
	endproperty
	a_mask_ones: assert property (p_mask_ones) // RL15
		else $error("reserved mask bits not read as one");

	// reset status reads the not-ready flag over zeros
	property p_por_read;
		(reg_rd && (reg_addr == `TASM_ADDR_POR_STATUS))
			|=> (reg_rdata == {$past(reset_in_progress_flag), 7'b000_0000});
	endproperty
	a_por_read: assert property (p_por_read) // RL16 RL17
		else $error("reset status register read wrong");

	// status read returns the latches as they stood at the strobe
	property p_status_read;
		rd_status |=> (((reg_rdata ^ $past(latched)) & 8'h5F) == 8'h00);
	endproperty
	a_status_read: assert property (p_status_read) // RL1 RL3 RL5 RL6 RL7 RL8 RL9
		else $error("status read data differs from the latches");

	// a mask write keeps only the alert-capable bits
	property p_mask_write;
		wr_mask |=> (alarm_mask == ($past(reg_wdata) & `TASM_ALERT_BITS));
	endproperty
	a_mask_write: assert property (p_mask_write) // RL10 RL11 RL12 RL13 RL14 RL15
		else $error("mask register took a wrong value");

	// mask holds between writes; a stray change would unmask silently
	property p_mask_hold;
		!wr_mask |=> $stable(alarm_mask);
	endproperty
	a_mask_hold: assert property (p_mask_hold) // RL10 RL11 RL12 RL13 RL14
		else $error("mask register changed without a write");

	// below the band the critical output is released
	property p_crit_release;
		crit_release |=> !critical_temp_output;
	endproperty
	a_crit_release: assert property (p_crit_release) // RL19
		else $error("critical output still set below the release point");

	// once ready, the not-ready flag only returns through a reset
	property p_por_stays;
		!reset_in_progress_flag |=> !reset_in_progress_flag;
	endproperty
	a_por_stays: assert property (p_por_stays) // RL16
		else $error("not-ready flag came back without a reset");

	// read valid is a single pulse per strobe
	property p_rvalid_pulse;
		!reg_rd |=> !reg_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse)
		else $error("read valid stood without a read strobe");

	// diode fault and busy alone drive neither pin
	property p_diode_quiet;
		((((latched | cond_vec) & 8'hFB) == 8'h00) && !critical_temp_output)
			|=> (!alert_oe && !critical_temp_output);
	endproperty
	a_diode_quiet: assert property (p_diode_quiet) // RL2 RL7
		else $error("diode fault or busy reached an output pin");

	// scenarios worth seeing
	c_read_clear: cover property (rd_status && (latched != 8'h00) ##1 (latched == 8'h00));
	c_comp_alert: cover property (comparator_mode_select && alert_oe);
	c_crit_band: cover property (critical_temp_output && !crit_cond && !crit_release);
	c_por_done: cover property ($fell(reset_in_progress_flag));
	c_diode_only: cover property (latched[`TASM_BIT_DIODE_FAULT] && !alert_oe);

endmodule

// ===== tb.sv
// self-checking bench for the alarm status and mask block
`timescale 1ns/100ps
`include "tasm_cfg.svh"

module tb;
	logic                 clk_sys      = 1'b0;
	logic                 resetn       = 1'b0;
	tasm_pkg::tasm_byte_t reg_addr     = 8'h00;
	logic                 reg_rd       = 1'b0;
	logic                 reg_wr       = 1'b0;
	tasm_pkg::tasm_byte_t reg_wdata    = 8'h00;
	tasm_pkg::tasm_byte_t reg_rdata;
	logic                 reg_rvalid;
	logic [7:0]           cond         = 8'h00;
	tasm_pkg::tasm_byte_t temp         = 8'h32;
	logic                 cmp_mode     = 1'b0;
	logic [6:0]           hyst         = 7'h0A;
	logic                 alert_oe;
	logic                 crit;
	logic                 not_ready;
	int                   err_count    = 0;
	int                   total_checks = 0;

	localparam logic [7:0] st = `TASM_ADDR_ALARM_STATUS;
	localparam logic [7:0] mk = `TASM_ADDR_ALARM_MASK;
	localparam logic [7:0] pr = `TASM_ADDR_POR_STATUS;
	// rows: {sources in status bit order, mask, expected alert}
	localparam logic [16:0] rows [13] = '{
		{8'h40, 8'h00, 1'b1}, {8'h40, 8'h40, 1'b0}, {8'h10, 8'h00, 1'b1},
		{8'h10, 8'h10, 1'b0}, {8'h08, 8'h00, 1'b1}, {8'h08, 8'h08, 1'b0},
		{8'h02, 8'h00, 1'b1}, {8'h02, 8'h02, 1'b0}, {8'h01, 8'h00, 1'b1},
		{8'h01, 8'h01, 1'b0}, {8'h04, 8'h00, 1'b0}, {8'h80, 8'h00, 1'b0},
		{8'h5B, 8'hFF, 1'b0}
	};

	always #5 clk_sys = ~clk_sys;

	// limit tied: its register sits outside this block; hysteresis is varied
	tasm_top i_tasm_top (
		.clk_sys                 (clk_sys),
		.resetn                  (resetn),
		.reg_addr                (reg_addr),
		.reg_rd                  (reg_rd),
		.reg_wr                  (reg_wr),
		.reg_wdata               (reg_wdata),
		.reg_rdata               (reg_rdata),
		.reg_rvalid              (reg_rvalid),
		.conv_busy               (cond[7]),
		.local_over_limit_cond   (cond[6]),
		.remote_over_limit_cond  (cond[4]),
		.remote_under_limit_cond (cond[3]),
		.diode_fault_cond        (cond[2]),
		.tach_over_limit_cond    (cond[0]),
		.remote_temp             (temp),
		.critical_limit          (8'h64),
		.crit_hysteresis         (hyst),
		.comparator_mode_select  (cmp_mode),
		.alert_oe                (alert_oe),
		.critical_temp_output    (crit),
		.reset_in_progress_flag  (not_ready)
	);

	////////////////////////////////////////////////////////////////////////
	// inputs change 1 ns after the edge so no race with sampling
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr  = a;
		reg_wdata = v;
		reg_wr    = 1'b1;
		tick();
		reg_wr    = 1'b0;
		tick();
	endtask

	// answer stands just after the edge that takes the strobe, for one cycle
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd   = 1'b1;
		tick();
		reg_rd   = 1'b0;
		chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
		chk(n, reg_rdata, e);
		tick();
		chk("rvalid_end", {7'h00, reg_rvalid}, 8'h00);
	endtask

	task automatic do_reset();
		resetn = 1'b0;
		repeat (8) tick();
		chk("not_ready", {7'h00, not_ready}, 8'h01);
		resetn = 1'b1;
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence: start-up reads and not-ready timing first, then the table, then the awkward cases
	initial begin
		do_reset();
		rchk("por", pr, 8'h80);
		rchk("mask", mk, 8'hA4);
		rchk("status", st, 8'h00);
		repeat (180) tick();
		chk("nr_early", {7'h00, not_ready}, 8'h01);
		repeat (20) tick();
		chk("nr_late", {7'h00, not_ready}, 8'h00);
		rchk("por_done", pr, 8'h00);
		foreach (rows[i]) begin
			wr(mk, rows[i][8:1]);
			rchk("mask_rb", mk, rows[i][8:1] | 8'hA4);
			cond = rows[i][16:9];
			temp = cond[1] ? 8'h78 : 8'h32;
			tick();
			cond[6:0] = 7'h00;
			temp = 8'h32;
			repeat (3) tick();
			chk("alert", {7'h00, alert_oe}, {7'h00, rows[i][0]});
			rchk("status", st, rows[i][16:9]);
			cond[7] = 1'b0;
			repeat (3) tick();
			chk("alert_clr", {7'h00, alert_oe}, 8'h00);
			rchk("status_clr", st, 8'h00);
		end
		// a source still present must survive the read
		cond = 8'h01;
		repeat (2) tick();
		rchk("held", st, 8'h01);
		rchk("held2", st, 8'h01);
		cond = 8'h00;
		tick();
		rchk("gone", st, 8'h01);
		rchk("gone2", st, 8'h00);
		// comparator mode drops alert with the source, latch kept
		wr(mk, 8'h00);
		cmp_mode = 1'b1;
		cond = 8'h08;
		repeat (3) tick();
		chk("cmp_on", {7'h00, alert_oe}, 8'h01);
		cond = 8'h00;
		repeat (3) tick();
		chk("cmp_off", {7'h00, alert_oe}, 8'h00);
		cmp_mode = 1'b0;
		repeat (3) tick();
		chk("latched", {7'h00, alert_oe}, 8'h01);
		rchk("cmp_st", st, 8'h08);
		// critical output boundaries and hysteresis, alert masked
		wr(mk, 8'h02);
		temp = 8'h64;
		repeat (3) tick();
		chk("crit_eq", {7'h00, crit}, 8'h00);
		temp = 8'h65;
		repeat (3) tick();
		chk("crit_on", {7'h00, crit}, 8'h01);
		chk("crit_msk", {7'h00, alert_oe}, 8'h00);
		temp = 8'h5A;
		repeat (3) tick();
		chk("crit_hold", {7'h00, crit}, 8'h01);
		temp = 8'h59;
		repeat (3) tick();
		chk("crit_off", {7'h00, crit}, 8'h00);
		// no hysteresis: held at the limit, released just below it
		hyst = 7'h00;
		temp = 8'h65;
		repeat (3) tick();
		chk("crit_h0_on", {7'h00, crit}, 8'h01);
		temp = 8'h64;
		repeat (3) tick();
		chk("crit_h0_hold", {7'h00, crit}, 8'h01);
		temp = 8'h63;
		repeat (3) tick();
		chk("crit_h0_off", {7'h00, crit}, 8'h00);
		rchk("crit_st", st, 8'h02);
		// writes to read-only places and an unmapped read
		wr(st, 8'hFF);
		wr(pr, 8'hFF);
		rchk("unmapped", 8'h40, 8'h00);
		rchk("st_ro", st, 8'h00);
		rchk("mask_keep", mk, 8'hA6);
		// second reset with a latch pending
		cond = 8'h40;
		tick();
		cond = 8'h00;
		do_reset();
		tick();
		chk("nr_again", {7'h00, not_ready}, 8'h01);
		chk("alert_rst", {7'h00, alert_oe}, 8'h00);
		rchk("mask_rst", mk, 8'hA4);
		rchk("st_rst", st, 8'h00);
		end_sim();
	end

	// watchdog: whole run needs well under 1000 cycles
	initial begin
		#50000;
		err_count++;
		end_sim();
	end
endmodule
